// ===== core/iq_pkg.sv
// constants and carrier types for the interrupt queue setup block
package iq_pkg;
   localparam int ADDR_W = 9;
   localparam logic [8:0] OFS_CONTROL = 9'h0e0;
   localparam logic [8:0] OFS_BASE = 9'h0e4;
   localparam logic [8:0] OFS_LENGTH = 9'h0e8;
   localparam logic [8:0] OFS_MASK = 9'h0ec;
   localparam logic [8:0] OFS_IRQ_STATUS = 9'h100;
   localparam logic [8:0] OFS_IRQ_MASK = 9'h104;
   localparam int BIT_LOAD_BASE = 16;
   localparam int BIT_LOAD_LEN = 17;
   localparam int BIT_LOAD_MASK = 18;
   localparam int BIT_DEBUG = 19;
   localparam logic [31:0] CONTROL_MASK = 32'h000f000f;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam int NUM_QUEUES = 9;
   localparam logic [3:0] NUM_QUEUES_Q = 4'h9;
   localparam logic [3:0] HIPRI_QUEUE = 4'h7;
   localparam logic [3:0] CMD_QUEUE = 4'h8;
   localparam logic [12:0] CMD_LEN_DW = 13'h0200;
   localparam int LEN_UNIT_LOG2 = 4;
   localparam int EVT_LOAD = 0;
   localparam int EVT_DEBUG = 1;
   localparam int EVT_FORWARD = 2;
   localparam int EVT_WRAP = 3;
   localparam int EVT_W = 4;

   typedef struct packed {
      logic [3:0] queue;
      logic [31:0] data;
   } vec_t;

   typedef struct packed {
      logic [3:0] queue;
      logic [31:0] addr;
      logic [31:0] data;
   } store_t;
endpackage

// ===== core/queue_setup_top.sv
// register front end and live settings of the nine interrupt queues
// Overview of operation
// RL1: a debug write copies the chosen queue's live base, length and mask into the staging registers.
// RL2: software sets the debug bit only in a write with no load bit set.
// RL3: a one on the mask load bit moves the staged mask into the chosen queue; a zero does nothing. Here queue 7 also ignores mask loads.
// RL4: software fills the mask staging register before loading a mask.
// RL5: a one on the length load bit moves the staged length into the chosen queue; a zero does nothing.
// RL6: software fills the length staging register before loading a length.
// RL7: a one on the base load bit replaces the chosen queue's base; a zero does nothing.
// RL8: software fills the base staging register before loading a base.
// RL9: a four-bit field picks the queue, 0 to 7 for channel queues and 8 for the command queue.
// RL10: queue seven is the high-priority queue.
// RL11: a channel vector sharing any set bit with its queue's mask goes to the high-priority queue.
// RL12: length and mask loads to the command queue are ignored and it keeps its fixed length.
// RL13: after a base or length change the next vector lands in the queue's first slot. Here a vector in the cycle after the load still uses the old pointer.
// RL14: a channel queue holds (staged length plus one) times sixteen double words.
// RL15: load bits are one-cycle strobes and all set in one write apply together.
// RL16: unused upper bits of the control register read zero and ignore writes.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
module queue_setup_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic vec_valid,
   input wire iq_pkg::vec_t vec,
   output logic store_valid,
   output iq_pkg::store_t store,
   output logic irq
);
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [31:0] read_mux;
   logic take;
   logic [31:0] ctrl_word;
   logic wr_ctrl;
   logic [3:0] q_eff;
   logic q_ok;
   logic load_base, load_len, load_mask, debug_go;
   logic [3:0] ctrl_queue_reg;
   logic [31:0] base_stage_reg;
   logic [7:0] len_stage_reg;
   logic [31:0] mask_stage_reg;
   logic [31:0] base_live [iq_pkg::NUM_QUEUES];
   logic [7:0] len_live [iq_pkg::NUM_QUEUES];
   logic [12:0] len_dw [iq_pkg::NUM_QUEUES];
   logic [31:0] mask_live [iq_pkg::NUM_QUEUES];
   logic [iq_pkg::NUM_QUEUES-1:0] restart_reg;
   logic [iq_pkg::EVT_W-1:0] status_reg, irq_mask_reg, evt, clr;
   logic irq_reg;
   logic forwarded, wrapped;
   logic [31:0] pick_base, pick_mask;
   logic [12:0] pick_len;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // one wait state per access; the write lands on the edge waitrequest is seen low
   assign take = avs_write && !waitrequest_reg;

   always_comb begin
      read_mux = iq_pkg::RESET_WORD;
      unique case (avs_address)
         iq_pkg::OFS_CONTROL: read_mux = {28'h0000000, ctrl_queue_reg}; // [RL15][RL16]
         iq_pkg::OFS_BASE: read_mux = base_stage_reg;
         iq_pkg::OFS_LENGTH: read_mux = {24'h000000, len_stage_reg};
         iq_pkg::OFS_MASK: read_mux = mask_stage_reg;
         iq_pkg::OFS_IRQ_STATUS: read_mux = {28'h0000000, status_reg};
         iq_pkg::OFS_IRQ_MASK: read_mux = {28'h0000000, irq_mask_reg};
         default: read_mux = iq_pkg::RESET_WORD;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitrequest_reg <= 1'b1;
         readdata_reg <= iq_pkg::RESET_WORD;
      end else if ((avs_read || avs_write) && waitrequest_reg) begin
         waitrequest_reg <= 1'b0;
         readdata_reg <= avs_read ? read_mux : iq_pkg::RESET_WORD;
      end else begin
         waitrequest_reg <= 1'b1;
      end
   end

   // control decode; only the queue field and the four action bits exist
   assign wr_ctrl = take && avs_address == iq_pkg::OFS_CONTROL;
   assign ctrl_word = merge(iq_pkg::RESET_WORD, avs_writedata, avs_byteenable)
                      & iq_pkg::CONTROL_MASK; // [RL16]
   // outside a control write the stored select rules, so idle bus data cannot steer it
   assign q_eff = (wr_ctrl && avs_byteenable[0]) ? ctrl_word[3:0] : ctrl_queue_reg; // [RL9]
   assign q_ok = q_eff < iq_pkg::NUM_QUEUES_Q; // [RL9]
   assign load_base = wr_ctrl && q_ok && ctrl_word[iq_pkg::BIT_LOAD_BASE]; // [RL7][RL15]
   assign load_len = wr_ctrl && q_ok && ctrl_word[iq_pkg::BIT_LOAD_LEN]; // [RL5][RL15]
   assign load_mask = wr_ctrl && q_ok && ctrl_word[iq_pkg::BIT_LOAD_MASK]; // [RL3][RL15]
   // a debug request mixed with loads is dropped so staging is never overwritten mid-load
   assign debug_go = wr_ctrl && q_ok && ctrl_word[iq_pkg::BIT_DEBUG]
                     && !(load_base || load_len || load_mask); // [RL2]

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_queue_reg <= 4'h0;
      end else if (wr_ctrl && avs_byteenable[0]) begin
         ctrl_queue_reg <= ctrl_word[3:0]; // [RL9]
      end
   end

   assign pick_base = q_ok ? base_live[q_eff] : iq_pkg::RESET_WORD;
   assign pick_mask = q_ok ? mask_live[q_eff] : iq_pkg::RESET_WORD;
   assign pick_len = q_ok ? len_dw[q_eff] : 13'h0000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         base_stage_reg <= iq_pkg::RESET_WORD;
         len_stage_reg <= 8'h00;
         mask_stage_reg <= iq_pkg::RESET_WORD;
      end else if (debug_go) begin
         base_stage_reg <= pick_base; // [RL1]
         len_stage_reg <= len_live[q_eff]; // [RL1]
         mask_stage_reg <= pick_mask; // [RL1]
      end else if (take) begin
         if (avs_address == iq_pkg::OFS_BASE) begin
            base_stage_reg <= merge(base_stage_reg, avs_writedata, avs_byteenable) & 32'hfffffffc;
         end
         if (avs_address == iq_pkg::OFS_LENGTH && avs_byteenable[0]) begin
            len_stage_reg <= avs_writedata[7:0];
         end
         if (avs_address == iq_pkg::OFS_MASK) begin
            mask_stage_reg <= merge(mask_stage_reg, avs_writedata, avs_byteenable);
         end
      end
   end

   for (genvar i = 0; i < iq_pkg::NUM_QUEUES; i++) begin : g_queue
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            base_live[i] <= iq_pkg::RESET_WORD;
            len_live[i] <= 8'h00;
            mask_live[i] <= iq_pkg::RESET_WORD;
            restart_reg[i] <= 1'b0;
         end else begin
            if (load_base && q_eff == 4'(i)) begin
               base_live[i] <= base_stage_reg; // [RL7]
            end
            // command queue keeps its fixed size; neither 7 nor 8 takes a mask
            if (load_len && q_eff == 4'(i) && 4'(i) != iq_pkg::CMD_QUEUE) begin
               len_live[i] <= len_stage_reg; // [RL5][RL12]
            end
            if (load_mask && q_eff == 4'(i) && 4'(i) < iq_pkg::HIPRI_QUEUE) begin
               mask_live[i] <= mask_stage_reg; // [RL3][RL12]
            end
            restart_reg[i] <= q_eff == 4'(i)
                              && (load_base || (load_len && 4'(i) != iq_pkg::CMD_QUEUE)); // [RL13]
         end
      end
      if (i == int'(iq_pkg::CMD_QUEUE)) begin : g_cmd
         assign len_dw[i] = iq_pkg::CMD_LEN_DW; // [RL12]
      end else begin : g_chan
         assign len_dw[i] = 13'({1'b0, len_live[i]} + 9'h001) << iq_pkg::LEN_UNIT_LOG2; // [RL14]
      end
   end

   vector_writer u_writer (
      .clk(clk),
      .rst_b(rst_b),
      .vec_valid(vec_valid),
      .vec(vec),
      .base_live(base_live),
      .len_dw(len_dw),
      .mask_live(mask_live),
      .restart(restart_reg),
      .store_valid_reg(store_valid),
      .store_reg(store),
      .forwarded_reg(forwarded),
      .wrapped_reg(wrapped)
   );

   // sticky events; a new event beats a same-cycle write-one clear
   assign evt[iq_pkg::EVT_LOAD] = load_base || load_len || load_mask;
   assign evt[iq_pkg::EVT_DEBUG] = debug_go;
   assign evt[iq_pkg::EVT_FORWARD] = forwarded;
   assign evt[iq_pkg::EVT_WRAP] = wrapped;
   assign clr = (take && avs_address == iq_pkg::OFS_IRQ_STATUS && avs_byteenable[0])
                ? avs_writedata[iq_pkg::EVT_W-1:0] : '0;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= '0;
         irq_mask_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~clr) | evt;
         if (take && avs_address == iq_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask_reg <= avs_writedata[iq_pkg::EVT_W-1:0];
         end
         irq_reg <= |(status_reg & irq_mask_reg);
      end
   end

   assign avs_waitrequest = waitrequest_reg;
   assign avs_readdata = readdata_reg;
   assign irq = irq_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_DEBUG_COPY: assert property (debug_go |=> base_stage_reg == $past(pick_base) // [RL1]
      && mask_stage_reg == $past(pick_mask))
      else $error("debug readback did not copy live settings");
   AST_MASK_LOAD: assert property (load_mask && q_eff < iq_pkg::HIPRI_QUEUE // [RL3]
      |=> pick_mask == $past(mask_stage_reg))
      else $error("mask load did not reach the queue");
   AST_MASK_ZERO: assert property (wr_ctrl && q_ok && !ctrl_word[iq_pkg::BIT_LOAD_MASK] // [RL3]
      |=> pick_mask == $past(pick_mask))
      else $error("mask changed without a load");
   AST_LEN_LOAD: assert property (load_len && q_eff != iq_pkg::CMD_QUEUE // [RL5][RL14]
      |=> pick_len == 13'({1'b0, $past(len_stage_reg)} + 9'h001) << iq_pkg::LEN_UNIT_LOG2)
      else $error("length load wrong");
   AST_BASE_LOAD: assert property (load_base |=> pick_base == $past(base_stage_reg)) // [RL7]
      else $error("base load did not reach the queue");
   AST_CMD_FIXED: assert property (len_live[iq_pkg::CMD_QUEUE] == 8'h00 // [RL12]
      && mask_live[iq_pkg::CMD_QUEUE] == iq_pkg::RESET_WORD)
      else $error("command queue length or mask changed");
   AST_QSEL: assert property (wr_ctrl && avs_byteenable[0] // [RL9]
      |=> ctrl_queue_reg == $past(avs_writedata[3:0]))
      else $error("queue select not stored");
   AST_CTRL_READ: assert property (avs_read && !avs_waitrequest // [RL15][RL16]
      && avs_address == iq_pkg::OFS_CONTROL |-> avs_readdata[31:4] == 28'h0000000)
      else $error("control register upper bits not zero");
   AST_RESTART_PULSE: assert property (|restart_reg |=> !(|restart_reg)) // [RL15]
      else $error("load strobe lasted more than one cycle");
   AST_EVT_WINS: assert property (evt[iq_pkg::EVT_LOAD] |=> status_reg[iq_pkg::EVT_LOAD])
      else $error("load event lost against a clear");

   COV_DEBUG: cover property (debug_go ##2 avs_read && avs_address == iq_pkg::OFS_BASE);
   COV_ALL_LOADS: cover property (load_base && load_len && load_mask);
   COV_IRQ: cover property (irq);
endmodule

// ===== core/vector_writer.sv
// routes incoming vectors to a queue and walks each queue's write pointer
`timescale 1ns/100ps
module vector_writer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic vec_valid,
   input wire iq_pkg::vec_t vec,
   input wire logic [31:0] base_live [iq_pkg::NUM_QUEUES],
   input wire logic [12:0] len_dw [iq_pkg::NUM_QUEUES],
   input wire logic [31:0] mask_live [iq_pkg::NUM_QUEUES],
   input wire logic [iq_pkg::NUM_QUEUES-1:0] restart,
   output logic store_valid_reg,
   output iq_pkg::store_t store_reg,
   output logic forwarded_reg,
   output logic wrapped_reg
);
   logic [11:0] ptr_reg [iq_pkg::NUM_QUEUES];
   logic [3:0] dest;
   logic fwd;
   logic go;
   logic wrap_now;

   always_comb begin
      dest = vec.queue;
      fwd = 1'b0;
      // queue 7 is the high-priority target and its own mask is never consulted
      if (vec.queue < iq_pkg::HIPRI_QUEUE && |(vec.data & mask_live[vec.queue])) begin // [RL11]
         dest = iq_pkg::HIPRI_QUEUE; // [RL10]
         fwd = 1'b1;
      end
   end

   assign go = vec_valid && (vec.queue < iq_pkg::NUM_QUEUES_Q);
   assign wrap_now = go && (({1'b0, ptr_reg[dest]} + 13'h0001) == len_dw[dest]);

   for (genvar i = 0; i < iq_pkg::NUM_QUEUES; i++) begin : g_ptr
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            ptr_reg[i] <= 12'h000;
         end else if (restart[i]) begin
            // a fresh base or length sends the pointer to the first slot one cycle after the load
            ptr_reg[i] <= 12'h000; // [RL13]
         end else if (go && dest == 4'(i)) begin
            ptr_reg[i] <= wrap_now ? 12'h000 : ptr_reg[i] + 12'h001;
         end
      end
      AST_RESTART_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
         restart[i] |=> ptr_reg[i] == 12'h000) // [RL13]
         else $error("queue pointer not back at first slot after setup change");
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         store_valid_reg <= 1'b0;
         store_reg <= '0;
         forwarded_reg <= 1'b0;
         wrapped_reg <= 1'b0;
      end else begin
         store_valid_reg <= go;
         store_reg.queue <= dest;
         store_reg.addr <= base_live[dest] + 32'({ptr_reg[dest], 2'b00});
         store_reg.data <= vec.data;
         forwarded_reg <= go && fwd;
         wrapped_reg <= wrap_now;
      end
   end

   AST_FORWARD_HIPRI: assert property (@(posedge clk) disable iff (!rst_b) // [RL10][RL11]
      go && vec.queue < iq_pkg::HIPRI_QUEUE && |(vec.data & mask_live[vec.queue])
      |=> store_valid_reg && store_reg.queue == iq_pkg::HIPRI_QUEUE && forwarded_reg)
      else $error("masked vector not sent to high-priority queue");
   AST_REGULAR_QUEUE: assert property (@(posedge clk) disable iff (!rst_b) // [RL11]
      go && (vec.queue >= iq_pkg::HIPRI_QUEUE || !(|(vec.data & mask_live[vec.queue])))
      |=> store_valid_reg && store_reg.queue == $past(vec.queue) && !forwarded_reg)
      else $error("unmasked vector left its own queue");
   COV_FORWARD: cover property (@(posedge clk) disable iff (!rst_b) forwarded_reg);
   COV_WRAP: cover property (@(posedge clk) disable iff (!rst_b) wrapped_reg);
endmodule

// ===== dv/queue_setup_top_tb.sv
// testbench for the interrupt queue setup block
`timescale 1ns/100ps
module queue_setup_top_tb;
   logic clk, rst_b, avs_read, avs_write, avs_waitrequest, vec_valid, store_valid, irq;
   logic [8:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic [15:0] n_st;
   iq_pkg::vec_t vec;
   iq_pkg::store_t store, last;
   int errors, n_tests;

   queue_setup_top i_queue_setup_top (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .vec_valid(vec_valid), .vec(vec),
      .store_valid(store_valid), .store(store), .irq(irq));
   shared_mem_model i_shared_mem_model (.clk(clk), .rst_b(rst_b), .store_valid(store_valid),
      .store(store), .last_store(last), .n_stores(n_st));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [67:0] seen, input logic [67:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   function automatic logic [31:0] ctl(input logic [3:0] q, input logic [3:0] act);
      return {12'h000, act, 12'h000, q};
   endfunction

   task automatic send_vec(input logic [3:0] q, input logic [31:0] d, input logic [3:0] eq,
      input logic [31:0] ea);
      logic [15:0] n0;
      n0 = n_st;
      @(posedge clk);
      vec_valid <= 1'b1;
      vec <= '{queue: q, data: d};
      @(posedge clk);
      vec_valid <= 1'b0;
      @(negedge clk);
      chk(store_valid, 1'b1, "store_valid");
      @(negedge clk);
      chk(store_valid, 1'b0, "store_pulse");
      chk(n_st, n0 + 16'h0001, "store_count");
      chk(last.queue, eq, "store_queue");
      chk(last.addr, ea, "store_addr");
      chk(last.data, d, "store_data");
   endtask

   task automatic readback(input logic [3:0] q, input logic [31:0] b, input logic [31:0] l,
      input logic [31:0] m);
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(q, 4'h8));
      bus(1'b0, iq_pkg::OFS_BASE, 32'h0);
      chk(rd, b, "debug_base");
      bus(1'b0, iq_pkg::OFS_LENGTH, 32'h0);
      chk(rd, l, "debug_length");
      bus(1'b0, iq_pkg::OFS_MASK, 32'h0);
      chk(rd, m, "debug_mask");
   endtask

   task automatic t_reset_and_fields();
      bus(1'b0, iq_pkg::OFS_CONTROL, 32'h0);
      chk(rd, 32'h00000000, "control_reset");
      bus(1'b0, 9'h0f0, 32'h0);
      chk(rd, 32'h00000000, "unmapped_read");
      bus(1'b1, iq_pkg::OFS_CONTROL, 32'hffffffff);
      bus(1'b0, iq_pkg::OFS_CONTROL, 32'h0);
      chk(rd, 32'h0000000f, "control_unused");
      bus(1'b1, iq_pkg::OFS_BASE, 32'h12345677);
      bus(1'b0, iq_pkg::OFS_BASE, 32'h0);
      chk(rd, 32'h12345674, "base_align");
      avs_byteenable <= 4'h1;
      bus(1'b1, iq_pkg::OFS_BASE, 32'hffffffff);
      avs_byteenable <= 4'hf;
      bus(1'b0, iq_pkg::OFS_BASE, 32'h0);
      chk(rd, 32'h123456fc, "base_byte_lane");
      $display("test reset_and_fields done");
   endtask

   task automatic t_load_and_walk();
      bus(1'b1, iq_pkg::OFS_BASE, 32'h00001000);
      bus(1'b1, iq_pkg::OFS_LENGTH, 32'h00000001);
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(4'h2, 4'h3));
      bus(1'b1, iq_pkg::OFS_BASE, 32'h0000aaa0);
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(4'h2, 4'h0));
      readback(4'h2, 32'h00001000, 32'h00000001, 32'h0);
      for (int i = 0; i <= 32; i++) begin
         send_vec(4'h2, 32'h0, 4'h2, 32'h00001000 + 32'(4 * (i % 32)));
      end
      bus(1'b1, iq_pkg::OFS_BASE, 32'h00002000);
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(4'h2, 4'h1));
      send_vec(4'h2, 32'h0, 4'h2, 32'h00002000);
      $display("test load_and_walk done");
   endtask

   task automatic t_priority();
      bus(1'b1, iq_pkg::OFS_MASK, 32'h00000010);
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(4'h3, 4'h4));
      send_vec(4'h3, 32'h00000011, iq_pkg::HIPRI_QUEUE, 32'h0);
      send_vec(4'h3, 32'h00000001, 4'h3, 32'h0);
      readback(4'h3, 32'h0, 32'h0, 32'h00000010);
      bus(1'b1, iq_pkg::OFS_LENGTH, 32'h00000005);
      bus(1'b1, iq_pkg::OFS_MASK, 32'h0000ffff);
      bus(1'b1, iq_pkg::OFS_BASE, 32'h00003000);
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(iq_pkg::CMD_QUEUE, 4'h7));
      readback(iq_pkg::CMD_QUEUE, 32'h00003000, 32'h0, 32'h0);
      $display("test priority done");
   endtask

   task automatic t_irq();
      bus(1'b1, iq_pkg::OFS_IRQ_STATUS, 32'h0000000f);
      bus(1'b0, iq_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h00000000, "status_clear");
      bus(1'b1, iq_pkg::OFS_CONTROL, ctl(4'h0, 4'h1));
      bus(1'b0, iq_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h00000001, "status_load");
      chk(irq, 1'b0, "irq_masked");
      bus(1'b1, iq_pkg::OFS_IRQ_MASK, 32'h00000001);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1, "irq_raised");
      bus(1'b1, iq_pkg::OFS_IRQ_STATUS, 32'h00000001);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0, "irq_cleared");
      $display("test irq done");
   endtask

   initial begin
      errors = 0;
      n_tests = 0;
      rst_b = 1'b0;
      avs_address = 9'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
      vec_valid = 1'b0;
      vec = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset_and_fields();
      t_load_and_walk();
      t_priority();
      t_irq();
      results();
   end

   // the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
endmodule

// ===== dv/shared_mem_model.sv
// shared-memory model that takes the vector stores of the queue block
`timescale 1ns/100ps
module shared_mem_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic store_valid,
   input wire iq_pkg::store_t store,
   output iq_pkg::store_t last_store,
   output logic [15:0] n_stores
);
   // memory accepts a store every cycle, so it never stalls the block; only the last is kept
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_store <= '0;
         n_stores <= 16'h0000;
      end else if (store_valid) begin
         last_store <= store;
         n_stores <= n_stores + 16'h0001;
      end
   end
endmodule
